// [hw/rbc_pkg.sv]
package rbc_pkg;

    // ==========================================================
    // Boot select encodings and strap defaults
    // ==========================================================
    localparam logic [1:0] BOOT_ROM_NAND = 2'h0; // ROM, NAND with SPI option
    localparam logic [1:0] BOOT_EMIF = 2'h1; // Direct async memory boot
    localparam logic [1:0] BOOT_ROM_CARD = 2'h2; // ROM, card port boot
    localparam logic [1:0] BOOT_ROM_SERIAL = 2'h3; // ROM, serial port boot
    localparam logic [1:0] BOOT_SEL_RST = 2'h0; // Pull default of boot select
    localparam logic [3:0] PIN_CFG_RST = 4'hD; // Pull default, NAND pinout

    // ==========================================================
    // Strap field positions on the address pins
    // ==========================================================
    localparam int BOOT_SEL_HI = 13;
    localparam int BOOT_SEL_LO = 12;
    localparam int PIN_CFG_HI = 11;
    localparam int PIN_CFG_LO = 8;

    // ==========================================================
    // Forced first fetch targets
    // ==========================================================
    localparam logic [31:0] ROM_START_ADDR = 32'h0000_8000;
    localparam logic [31:0] EMIF_BASE_ADDR = 32'h0200_0000;

    // ==========================================================
    // Timing of the internal reset pulse
    // ==========================================================
    localparam int CLK_PERIOD_NS = 50; // 20 MHz reference
    localparam int RST_TIME_NS = 800; // Least internal reset width
    localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] RST_CNT_LOAD = 5'(RST_CYCLES - 1);

    // ==========================================================
    // Module indices for software module reset
    // ==========================================================
    localparam int NUM_MODS = 7;
    localparam logic [2:0] MOD_ASYNC_MEM = 3'h2; // Async memory interface index

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [3:0] {
        ST_RUN = 4'h1, // Normal operation
        ST_PIN = 4'h2, // Global reset pin held low
        ST_MAX = 4'h4, // Max reset in progress, pins not involved
        ST_WAIT = 4'h8 // Reset tail, modules held before release
    } rbc_state_type;

    typedef enum logic [3:0] {
        K_POR = 4'h1,
        K_WARM = 4'h2,
        K_MAX = 4'h4,
        K_SYS = 4'h8
    } rbc_kind_type;

    typedef struct packed {
        logic cpu; // Processor reset
        logic periph; // Ordinary peripherals
        logic mem; // On-chip memories
        logic ddr; // DDR memory controller
        logic pll_pwr; // PLL and power/sleep controllers
        logic emul; // Emulation logic
    } rbc_scope_type;

    typedef struct packed {
        logic dma_cc;
        logic dma_tc;
        logic async_ext_mem_if;
        logic card0;
        logic serial0;
        logic timer0;
        logic spi_port_zero;
        logic nand_cs0; // Chip select zero carries NAND
        logic emif_cs0; // Chip select zero carries boot flash
    } rbc_mod_en_type;

    typedef struct packed {
        logic [4:0] setup;
        logic [6:0] strobe;
        logic [3:0] hold;
    } rbc_wait_type;

    typedef struct packed {
        logic enable;
        logic bypass;
    } rbc_pll_type;

    localparam rbc_wait_type WAIT_RST = '{setup: 5'h10, strobe: 7'h40, hold: 4'h8};
    localparam rbc_pll_type PLL_RST = '{enable: 1'b0, bypass: 1'b1};

endpackage

// [hw/rbc_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Three-stage pin synchroniser with agreement filter
// ==========================================================
module rbc_pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Asynchronous pins and filtered result
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] ff1; // Metastability stage, read by ff2 only
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] next_out;

    // Accept a bit only once the last two stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_out[i] = (ff2[i] == ff3[i]) ? ff3[i] : pin_out[i];
        end
    end

    // Register stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            pin_out <= '0;
        end else begin
            ff1 <= pin_in;
            ff2 <= ff1;
            ff3 <= ff2;
            pin_out <= next_out;
        end
    end

endmodule // rbc_pin_sync

`default_nettype wire

// [hw/rbc_strap_latch.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Strap capture register
// ==========================================================
module rbc_strap_latch (
    // Clock and power reset
    input wire logic ref_clk,
    input wire logic rst,
    // Capture strobe and synchronised address pins
    input wire logic capture,
    input wire logic [13:8] ext_mem_addr_pins,
    // Latched straps
    output logic [1:0] boot_select_strap,
    output logic [3:0] ext_mem_pin_cfg_strap
);
    import rbc_pkg::*;

    logic [1:0] next_boot;
    logic [3:0] next_cfg;

    // Only a capture strobe updates; system and module resets never reach here
    always_comb begin
        next_boot = boot_select_strap;
        next_cfg = ext_mem_pin_cfg_strap;
        if (capture) begin
            next_boot = ext_mem_addr_pins[BOOT_SEL_HI:BOOT_SEL_LO]; // RULE5
            next_cfg = ext_mem_addr_pins[PIN_CFG_HI:PIN_CFG_LO]; // RULE6
        end
    end

    // Register, with pull defaults before the first capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boot_select_strap <= BOOT_SEL_RST; // RULE5
            ext_mem_pin_cfg_strap <= PIN_CFG_RST; // RULE6
        end else begin
            boot_select_strap <= next_boot; // RULE18
            ext_mem_pin_cfg_strap <= next_cfg;
        end
    end

endmodule // rbc_strap_latch

`default_nettype wire

// [hw/rbc_reset_seq.sv]
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1 - System reset spares memories, DDR, PLL, emulation
// RULE2 - Processor released after modules finish reset; code releases processor and modules on the same clock edge
// RULE3 - Module reset pulses only the chosen module
// RULE4 - Straps sampled, then pins become memory pins
// RULE5 - Boot select from address bits 13:12
// RULE6 - Pin config from address bits 11:8
// RULE7 - Pin config governs boot modes 00, 01
// RULE8 - ROM boot forces jump to ROM start
// RULE9 - Async boot forces jump to memory base
// RULE10 - Wait states reset to slowest on enable
// RULE11 - PLLs disabled and bypassed after hard reset
// RULE12 - Debugger may block watchdog max reset
// RULE13 - Module enables follow boot select strap
// RULE14 - Boot status pin driven in ROM boot
// RULE15 - Board puts boot flash on chip select zero
// RULE16 - Straps captured on global reset rising edge
// RULE17 - Warm reset: test reset high, global low
// RULE18 - Latched straps survive system and module reset

module rbc_reset_seq (
    // Clock and power reset
    input wire logic ref_clk,
    input wire logic rst,
    // Board pins
    input wire logic global_rst_n,
    input wire logic test_port_rst_n,
    input wire logic [13:8] ext_mem_addr_pins,
    // Debug and watchdog requests, one-cycle pulses; the max reset block is a level
    input wire logic emu_sys_rst_req,
    input wire logic emu_max_rst_req,
    input wire logic emu_block_max_rst,
    input wire logic watchdog_expire,
    // Software module reset and configuration writes
    input wire logic mod_rst_req,
    input wire logic [2:0] mod_rst_sel,
    input wire logic mem_wait_wr,
    input wire rbc_pkg::rbc_wait_type mem_wait_wdata,
    input wire logic pll_wr,
    input wire rbc_pkg::rbc_pll_type pll_wdata,
    input wire logic boot_status_level,
    // Processor first fetch
    input wire logic cpu_fetch_ack,
    output logic force_fetch_valid,
    output logic [31:0] force_fetch_addr,
    // Reset distribution
    output rbc_pkg::rbc_scope_type rst_scope,
    output logic [6:0] module_rst,
    // Straps and pin function
    output logic [1:0] boot_select_strap,
    output logic [3:0] ext_mem_pin_cfg_strap,
    output logic pin_fn_emif,
    output logic emif_pin_cfg_valid,
    // Configuration defaults
    output rbc_pkg::rbc_mod_en_type mod_en,
    output rbc_pkg::rbc_wait_type mem_wait,
    output rbc_pkg::rbc_pll_type pll_cfg,
    // Boot status pin
    output logic boot_status_out,
    output logic boot_status_oe
);
    import rbc_pkg::*;

    // ==========================================================
    // Decoding helpers
    // ==========================================================
    function automatic logic is_rom(input logic [1:0] sel);
        is_rom = (sel != BOOT_EMIF);
    endfunction

    // NAND boot falls back to card boot, so both ports come up
    function automatic rbc_mod_en_type strap_enables(input logic [1:0] sel);
        strap_enables = '0;
        strap_enables.dma_cc = is_rom(sel);
        strap_enables.dma_tc = is_rom(sel);
        strap_enables.timer0 = is_rom(sel);
        strap_enables.async_ext_mem_if = (sel == BOOT_ROM_NAND) || (sel == BOOT_EMIF);
        strap_enables.spi_port_zero = (sel == BOOT_ROM_NAND);
        strap_enables.card0 = (sel == BOOT_ROM_NAND) || (sel == BOOT_ROM_CARD);
        strap_enables.serial0 = (sel == BOOT_ROM_SERIAL);
        strap_enables.nand_cs0 = (sel == BOOT_ROM_NAND);
        strap_enables.emif_cs0 = (sel == BOOT_EMIF); // RULE15
    endfunction

    // ==========================================================
    // Pin synchronisation and strap capture
    // ==========================================================
    logic [7:0] pins_s; // Filtered pins
    logic glob_n_s; // Filtered global reset
    logic trst_n_s; // Filtered test port reset
    logic capture; // Strap capture strobe

    rbc_pin_sync #(.WIDTH(8)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in({global_rst_n, test_port_rst_n, ext_mem_addr_pins}),
        .pin_out(pins_s)
    );
    assign glob_n_s = pins_s[7];
    assign trst_n_s = pins_s[6];

    rbc_strap_latch u_strap (
        .ref_clk(ref_clk),
        .rst(rst),
        .capture(capture),
        .ext_mem_addr_pins(pins_s[5:0]),
        .boot_select_strap(boot_select_strap),
        .ext_mem_pin_cfg_strap(ext_mem_pin_cfg_strap)
    );

    // ==========================================================
    // Reset sequencer
    // ==========================================================
    rbc_state_type state;
    rbc_state_type next_state;
    rbc_kind_type kind; // Kind of the reset under way
    rbc_kind_type next_kind;
    logic [4:0] cnt; // Reset tail counter
    logic [4:0] next_cnt;
    logic max_req; // Max reset that survived blocking
    logic in_rst; // Chip held in reset next cycle
    logic hard; // Reset is not the soft system kind

    assign max_req = emu_max_rst_req || (watchdog_expire && !emu_block_max_rst); // RULE12

    // Pin reset outranks everything; a max reset then latches straps itself
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_cnt = cnt;
        capture = 1'b0;
        case (state)
            ST_RUN: begin
                if (!glob_n_s) begin
                    next_state = ST_PIN;
                    next_kind = trst_n_s ? K_WARM : K_POR; // RULE17
                end else if (max_req) begin
                    next_state = ST_MAX;
                    next_kind = K_MAX;
                    next_cnt = RST_CNT_LOAD;
                end else if (emu_sys_rst_req) begin
                    next_state = ST_WAIT;
                    next_kind = K_SYS; // RULE1
                    next_cnt = RST_CNT_LOAD;
                end
            end
            ST_PIN: begin
                if (!trst_n_s) begin
                    next_kind = K_POR; // RULE17
                end
                if (glob_n_s) begin
                    capture = 1'b1; // RULE16
                    next_state = ST_WAIT;
                    next_cnt = RST_CNT_LOAD;
                end
            end
            ST_MAX: begin
                if (!glob_n_s) begin
                    next_state = ST_PIN;
                end else if (cnt == 5'h0) begin
                    capture = 1'b1; // RULE16
                    next_state = ST_WAIT;
                    next_cnt = RST_CNT_LOAD;
                end else begin
                    next_cnt = cnt - 5'h1;
                end
            end
            ST_WAIT: begin
                if (!glob_n_s) begin
                    next_state = ST_PIN;
                    next_kind = trst_n_s ? K_WARM : K_POR;
                end else if (cnt == 5'h0) begin
                    next_state = ST_RUN; // RULE2
                end else begin
                    next_cnt = cnt - 5'h1;
                end
            end
            default: begin
                next_state = ST_PIN;
                next_kind = K_POR;
            end
        endcase
    end

    // Register sequencer state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_PIN;
            kind <= K_POR;
            cnt <= 5'h0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            cnt <= next_cnt;
        end
    end

    // ==========================================================
    // Reset scope and pin function
    // ==========================================================
    rbc_scope_type next_scope;
    logic next_pin_fn;

    assign in_rst = (next_state != ST_RUN);
    assign hard = (next_kind != K_SYS);

    // Soft reset leaves memory, clocks and power state alone
    always_comb begin
        next_scope.cpu = in_rst; // RULE2
        next_scope.periph = in_rst;
        next_scope.mem = in_rst && hard; // RULE1
        next_scope.ddr = in_rst && hard;
        next_scope.pll_pwr = in_rst && hard;
        next_scope.emul = in_rst && (next_kind == K_POR);
        next_pin_fn = pin_fn_emif;
        if (capture) begin
            next_pin_fn = 1'b1; // RULE4
        end else if (next_state == ST_PIN || next_state == ST_MAX) begin
            next_pin_fn = 1'b0;
        end
    end

    // Register scope
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_scope <= '1;
            pin_fn_emif <= 1'b0;
        end else begin
            rst_scope <= next_scope;
            pin_fn_emif <= next_pin_fn;
        end
    end

    // ==========================================================
    // Software module reset
    // ==========================================================
    logic mod_busy; // A module pulse is running
    logic next_mod_busy;
    logic [2:0] mod_sel;
    logic [2:0] next_mod_sel;
    logic [4:0] mod_cnt;
    logic [4:0] next_mod_cnt;
    logic [6:0] next_module_rst;

    // Requests while busy or out of range are dropped
    always_comb begin
        next_mod_busy = mod_busy;
        next_mod_sel = mod_sel;
        next_mod_cnt = mod_cnt;
        if (!mod_busy) begin
            if (mod_rst_req && (int'(mod_rst_sel) < NUM_MODS)) begin
                next_mod_busy = 1'b1;
                next_mod_sel = mod_rst_sel;
                next_mod_cnt = RST_CNT_LOAD;
            end
        end else if (mod_cnt == 5'h0) begin
            next_mod_busy = 1'b0;
        end else begin
            next_mod_cnt = mod_cnt - 5'h1;
        end
    end

    // Same line as a full reset, so the module lands in its power-on state
    for (genvar i = 0; i < NUM_MODS; i++) begin : g_mod
        assign next_module_rst[i] = next_scope.periph || (mod_busy && (mod_sel == 3'(i))); // RULE3
    end

    // Register module reset state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mod_busy <= 1'b0;
            mod_sel <= 3'h0;
            mod_cnt <= 5'h0;
            module_rst <= '1;
        end else begin
            mod_busy <= next_mod_busy;
            mod_sel <= next_mod_sel;
            mod_cnt <= next_mod_cnt;
            module_rst <= next_module_rst;
        end
    end

    // ==========================================================
    // Default configuration, first fetch and boot status pin
    // ==========================================================
    rbc_mod_en_type next_mod_en;
    rbc_wait_type next_wait;
    rbc_pll_type next_pll;
    logic next_fetch_valid;
    logic [31:0] next_fetch_addr;
    logic next_bs_out;
    logic next_bs_oe;
    logic next_cfg_valid;

    // Resets win over software writes
    always_comb begin
        next_mod_en = (in_rst && hard) ? '0 : strap_enables(boot_select_strap); // RULE13
        next_wait = mem_wait;
        if ((in_rst && hard) || next_module_rst[MOD_ASYNC_MEM]
            || (next_mod_en.async_ext_mem_if && !mod_en.async_ext_mem_if)) begin
            next_wait = WAIT_RST; // RULE10
        end else if (mem_wait_wr) begin
            next_wait = mem_wait_wdata;
        end
        next_pll = pll_cfg;
        if (in_rst && hard) begin
            next_pll = PLL_RST; // RULE11
        end else if (pll_wr) begin
            next_pll = pll_wdata;
        end
        next_fetch_valid = force_fetch_valid && !cpu_fetch_ack && !in_rst;
        next_fetch_addr = force_fetch_addr;
        if (state == ST_WAIT && next_state == ST_RUN) begin
            next_fetch_valid = 1'b1;
            next_fetch_addr = is_rom(boot_select_strap) ? ROM_START_ADDR : EMIF_BASE_ADDR; // RULE8 RULE9
        end
        next_bs_oe = !in_rst && is_rom(boot_select_strap); // RULE14
        next_bs_out = next_bs_oe && boot_status_level;
        next_cfg_valid = next_pin_fn && !is_rom(boot_select_strap ^ 2'h1); // RULE7
        next_cfg_valid = next_cfg_valid || (next_pin_fn && boot_select_strap == BOOT_EMIF);
    end

    // Register configuration outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mod_en <= '0;
            mem_wait <= WAIT_RST;
            pll_cfg <= PLL_RST;
            force_fetch_valid <= 1'b0;
            force_fetch_addr <= ROM_START_ADDR;
            boot_status_out <= 1'b0;
            boot_status_oe <= 1'b0;
            emif_pin_cfg_valid <= 1'b0;
        end else begin
            mod_en <= next_mod_en;
            mem_wait <= next_wait;
            pll_cfg <= next_pll;
            force_fetch_valid <= next_fetch_valid;
            force_fetch_addr <= next_fetch_addr;
            boot_status_out <= next_bs_out;
            boot_status_oe <= next_bs_oe;
            emif_pin_cfg_valid <= next_cfg_valid;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sys_soft_a: assert property (kind == K_SYS |-> !(rst_scope.mem || rst_scope.ddr || rst_scope.pll_pwr || rst_scope.emul)) // RULE1
        else $error("system reset touched a spared block");
    cpu_release_a: assert property (state == ST_WAIT && cnt == 5'h0 && glob_n_s |=> !rst_scope.cpu && state == ST_RUN) // RULE2
        else $error("processor not released at reset end");
    mod_pulse_a: assert property (mod_rst_req && !mod_busy && mod_rst_sel == 3'h4 && !next_scope.periph ##1 !next_scope.periph
        |=> module_rst[4] && ($countones(module_rst) == 1)) // RULE3
        else $error("module reset hit wrong module");
    pin_fn_a: assert property ($rose(pin_fn_emif) |-> $past(capture)) // RULE4
        else $error("pins switched without capture");
    strap_hold_a: assert property (state == ST_RUN && $past(state) == ST_RUN |-> $stable(boot_select_strap)
        && $stable(ext_mem_pin_cfg_strap)) // RULE18
        else $error("strap changed outside reset");
    rom_jump_a: assert property (force_fetch_valid && is_rom(boot_select_strap) |-> force_fetch_addr == ROM_START_ADDR) // RULE8
        else $error("ROM boot fetch address wrong");
    emif_jump_a: assert property (force_fetch_valid && !is_rom(boot_select_strap) |-> force_fetch_addr == EMIF_BASE_ADDR) // RULE9
        else $error("async boot fetch address wrong");
    wait_def_a: assert property ($rose(mod_en.async_ext_mem_if) |-> mem_wait == WAIT_RST) // RULE10
        else $error("wait states not slowest on enable");
    pll_def_a: assert property (state == ST_PIN |=> pll_cfg == PLL_RST) // RULE11
        else $error("PLL not bypassed in reset");
    watchdog_block_a: assert property (state == ST_RUN && glob_n_s && watchdog_expire && emu_block_max_rst && !emu_max_rst_req
        && !emu_sys_rst_req |=> state == ST_RUN) // RULE12
        else $error("blocked watchdog still reset chip");
    serial_en_a: assert property (boot_select_strap == BOOT_ROM_SERIAL && !rst_scope.periph && $past(!rst_scope.periph)
        |-> mod_en.serial0) // RULE13
        else $error("serial port not enabled for serial boot");
    boot_pin_a: assert property (state == ST_RUN && $past(state) == ST_RUN && is_rom(boot_select_strap) |-> boot_status_oe) // RULE14
        else $error("boot status pin not driven");

    sys_rst_c: cover property (state == ST_WAIT && kind == K_SYS);
    watchdog_block_c: cover property (state == ST_RUN && watchdog_expire && emu_block_max_rst);
    emif_boot_c: cover property (force_fetch_valid && !is_rom(boot_select_strap));
    mod_rst_c: cover property ($rose(mod_busy));

endmodule // rbc_reset_seq

`default_nettype wire

// [bench/rbc_board.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========
// Board reset driver and strap pins
// ==========
module rbc_board (
    // Bench commands
    input wire logic hold,
    input wire logic warm,
    input wire logic [5:0] strap,
    // Pin direction from device
    input wire logic pin_fn_emif,
    // Board pins
    output logic global_rst_n,
    output logic test_port_rst_n,
    output logic [13:8] ext_mem_addr_pins
);
    // Warm reset keeps test reset high
    assign test_port_rst_n = warm;
    assign global_rst_n = !hold;
    // Boot flash on chip select zero; once the pins turn over,
    // they show the inverse so a stale latch is caught
    assign ext_mem_addr_pins = pin_fn_emif ? ~strap : strap;
endmodule // rbc_board
`default_nettype wire

// [bench/reset_boot_config_latch_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module reset_boot_config_latch_tb;
    import rbc_pkg::*;
    logic ref_clk = 0, rst = 1, hold = 1, warm = 0;
    logic sq = 0, mx = 0, blk = 0, wdog = 0, mrq = 0, ack = 0;
    logic ww = 0, pw = 0, lvl = 0;
    logic [5:0] strap = 6'h0D;
    logic [2:0] msel = 3'h0;
    int fails = 0, checks = 0;
    wire logic g_n, t_n, ffv, pfe, cfgv, bsoe, bso;
    wire logic [13:8] pins;
    logic [31:0] ffa;
    logic [6:0] mrst;
    logic [1:0] bs_q;
    logic [3:0] pc_q;
    rbc_scope_type sc;
    rbc_mod_en_type men;
    rbc_wait_type wt;
    rbc_pll_type pll;

    rbc_board rbc_board_i (.hold(hold), .warm(warm), .strap(strap), .pin_fn_emif(pfe),
        .global_rst_n(g_n), .test_port_rst_n(t_n), .ext_mem_addr_pins(pins));
    rbc_reset_seq rbc_reset_seq_i (.ref_clk(ref_clk), .rst(rst), .global_rst_n(g_n),
        .test_port_rst_n(t_n), .ext_mem_addr_pins(pins), .emu_sys_rst_req(sq),
        .emu_max_rst_req(mx), .emu_block_max_rst(blk), .watchdog_expire(wdog), .mod_rst_req(mrq),
        .mod_rst_sel(msel), .mem_wait_wr(ww), .mem_wait_wdata(16'h0421), .pll_wr(pw),
        .pll_wdata(2'h2), .boot_status_level(lvl), .cpu_fetch_ack(ack),
        .force_fetch_valid(ffv), .force_fetch_addr(ffa), .rst_scope(sc), .module_rst(mrst),
        .boot_select_strap(bs_q), .ext_mem_pin_cfg_strap(pc_q), .pin_fn_emif(pfe),
        .emif_pin_cfg_valid(cfgv), .mod_en(men), .mem_wait(wt), .pll_cfg(pll),
        .boot_status_out(bso), .boot_status_oe(bsoe));

    // 20 MHz reference
    always #25 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Bounded wait for processor release
    task automatic wfetch();
        int i;
        for (i = 0; i < 200 && ffv !== 1'b1; i++) cyc(1);
        if (i == 200) begin
            fails++;
            $display("[ERR] %0t fetch timeout", $time);
            wrap_up();
        end else begin
            chk(sc.cpu, 0);
            ack = 1;
            cyc(1);
            ack = 0;
        end
    endtask
    // Hard reset with chosen straps; software first moves PLL and wait states off their defaults, except in the first call, where reset overrides the writes
    task automatic t_boot(input logic [1:0] bs, input logic w);
        ww = 1;
        pw = 1;
        cyc(1);
        ww = 0;
        pw = 0;
        hold = 1;
        warm = w;
        strap = {bs, 4'h6};
        cyc(6);
        chk(sc.emul, !w);
        hold = 0;
        wfetch();
        chk(ffa, bs == 2'h1 ? 32'h0200_0000 : 32'h0000_8000);
        chk({bs_q, pc_q}, strap);
        chk(pfe, 1);
        chk(pll, 2'h1);
        chk(wt, {5'h10, 7'h40, 4'h8});
        chk(men.serial0, bs == 2'h3);
        chk(bsoe, bs != 2'h1);
        chk(cfgv, !bs[1]);
        chk(men.emif_cs0, bs == 2'h1);
        chk(bso, 0);
        lvl = 1;
        cyc(1);
        chk(bso, bs != 2'h1);
        lvl = 0;
        $display("boot %0d done", bs);
    endtask
    // Soft reset spares memory, clocks, emulation
    task automatic t_sys();
        sq = 1;
        cyc(1);
        sq = 0;
        cyc(2);
        chk(sc, 6'h30);
        wfetch();
        chk({bs_q, pc_q}, strap);
        $display("system reset done");
    endtask
    task automatic t_mod();
        msel = 3'h4;
        mrq = 1;
        cyc(1);
        mrq = 0;
        cyc(2);
        chk(mrst, 7'h10);
        cyc(20);
        chk(mrst, 0);
        $display("module reset done");
    endtask
    // Blocked watchdog, then debugger max reset
    task automatic t_blk();
        blk = 1;
        wdog = 1;
        cyc(1);
        wdog = 0;
        cyc(20);
        chk(sc.cpu, 0);
        mx = 1;
        cyc(1);
        mx = 0;
        cyc(3);
        chk(sc.cpu, 1);
        wfetch();
        $display("block test done");
    endtask

    initial begin
        cyc(8);
        rst = 0;
        chk({bs_q, pc_q}, 6'h0D);
        t_boot(2'h0, 0);
        t_boot(2'h1, 1);
        t_boot(2'h2, 0);
        t_boot(2'h3, 1);
        t_sys();
        t_mod();
        t_blk();
        wrap_up();
    end
endmodule // reset_boot_config_latch_tb
`default_nettype wire
